// ---- logic/lcac_cluster.sv ----
// Summary of operation
// - Extended mode: seven-input function is a 2-to-1 mux of two five-input functions.
// - Unregistered extended function frees the eighth input for a packed register.
// - Arithmetic mode: two pairs of four-input tables feed two full adders.
// - All four arithmetic tables see the same two shared inputs.
// - Carry ripples in, through first then second adder, into next cell.
// - Adder sums are available registered, unregistered, or both.
// - Carry may be used with table outputs; the sum is then dropped.
// - Max-select: carry is one when X below Y and drives sync load.
// - Sync load captures the alternate input; otherwise normal data is captured.
// - Counter enable and add/sub come from shared inputs a and b; clock enable is a cluster input.
// - Sync clear and sync load act on every cluster register together.
// - Carry chains start at cell one or five; final carry goes to routing.
// - Sixteen bits per cluster; longer chains continue into the next cluster.
// - Half chains continue into the same half of the next cluster.
// - Columns alternate between top-half and bottom-half bypass.
// - Shared mode: tables form sum and carry bits of three operands.
// - Table carries travel the shared chain to the next adder.
// - Shared mode leaves both upper-select inputs free for packed registers.
// - Shared chains start at cell one or five and bypass halves likewise.
// - Registers cascade as a shift register while tables stay combinational.
// - Registers take data, clock, enable, sync and async clear, load, preset.
`timescale 1ns/1ps

module lcac_cluster #(
  parameter bit TOP_HALF_BYPASS = 1'b1
) (
  input  wire logic        CLK_SYS,
  input  wire logic        RESET,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic [63:0] CELL_DATA,
  input  wire logic        CARRY_IN,
  input  wire logic        SHARE_IN,
  input  wire logic        REG_CHAIN_IN,
  input  wire logic        CLK_ENABLE,
  input  wire logic        SYNC_CLEAR,
  input  wire logic        SYNC_LOAD,
  input  wire logic [15:0] ALT_DATA,
  input  wire logic        CELL_ACLR,
  input  wire logic        CELL_APRESET,
  output logic      [15:0] COMB_OUT,
  output logic      [15:0] REG_OUT,
  output logic             CARRY_OUT,
  output logic             ROUTED_CARRY,
  output logic             SHARE_OUT,
  output logic             REG_CHAIN_OUT
);

  // Table lookups and adder carry, used by every cell
  function automatic logic lut4(input logic [15:0] mask, input logic [3:0] sel);
    lut4 = mask[sel];
  endfunction : lut4

  function automatic logic lut5(input logic [31:0] mask, input logic [4:0] sel);
    lut5 = mask[sel];
  endfunction : lut5

  function automatic logic majority(input logic x, input logic y, input logic z);
    majority = (x & y) | (x & z) | (y & z);
  endfunction : majority

  logic [lcac_pkg::CTRL_WIDTH-1:0] ctrl_reg;
  logic [31:0]                     mask_a_reg;
  logic [31:0]                     mask_b_reg;
  logic [31:0]                     rd_mux;
  logic                            addr_hit;
  logic                            wr_fire;
  logic [15:0]                     regs_reg;
  logic [15:0]                     reg_next;
  logic [15:0]                     reg_we;
  logic [15:0]                     comb_val;
  logic                            load_seen_reg;
  lcac_pkg::lcac_mode_e            mode;
  logic [2:0]                      chain_lo;
  logic [2:0]                      chain_hi;
  logic                            subtract;
  logic                            cin_start;
  logic                            sin_start;
  logic                            c_run;
  logic                            s_run;
  logic                            load_sel;
  logic [7:0]                      cd;
  logic                            in_chain;
  logic                            opa0;
  logic                            opb0;
  logic                            opa1;
  logic                            opb1;
  logic                            cr0;
  logic                            cr1;
  logic                            ci0;
  logic                            co0;
  logic                            co1;
  logic                            sm0;
  logic                            sm1;
  logic                            fa5;
  logic                            fb5;
  logic [7:0]                      cnt_en;

  // APB decode; status is read-only, so writes to it are dropped quietly
  always_comb begin
    addr_hit = 1'b1;
    rd_mux   = 32'h0000_0000;
    unique case (PADDR)
      lcac_pkg::OFFS_CTRL:   rd_mux[lcac_pkg::CTRL_WIDTH-1:0] = ctrl_reg;
      lcac_pkg::OFFS_MASK_A: rd_mux = mask_a_reg;
      lcac_pkg::OFFS_MASK_B: rd_mux = mask_b_reg;
      lcac_pkg::OFFS_STATUS: rd_mux = {13'h0000, load_seen_reg, SHARE_OUT, ROUTED_CARRY, regs_reg};
      default:               addr_hit = 1'b0;
    endcase
  end

  assign wr_fire = PSEL & PENABLE & PREADY & PWRITE & addr_hit;

  // One wait-free access cycle; answer is prepared at the setup edge
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= PSEL & ~PENABLE;
      if (PSEL & ~PENABLE) begin
        PRDATA  <= PWRITE ? 32'h0000_0000 : rd_mux;
        PSLVERR <= ~addr_hit;
      end
    end
  end

  // Configuration registers steer the whole cluster
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      ctrl_reg   <= lcac_pkg::CTRL_RESET;
      mask_a_reg <= lcac_pkg::MASK_RESET;
      mask_b_reg <= lcac_pkg::MASK_RESET;
    end else if (wr_fire) begin
      if (PADDR == lcac_pkg::OFFS_CTRL) begin
        ctrl_reg <= PWDATA[lcac_pkg::CTRL_WIDTH-1:0];
      end
      if (PADDR == lcac_pkg::OFFS_MASK_A) begin
        mask_a_reg <= PWDATA;
      end
      if (PADDR == lcac_pkg::OFFS_MASK_B) begin
        mask_b_reg <= PWDATA;
      end
    end
  end

  assign mode = lcac_pkg::lcac_mode_e'(ctrl_reg[lcac_pkg::CTRL_MODE_LO +: 2]);

  // Chain span: full cluster from cell one or five, or the half this column may use
  always_comb begin
    if (ctrl_reg[lcac_pkg::CTRL_HALF_CHAIN]) begin
      chain_lo = TOP_HALF_BYPASS ? 3'd4 : 3'd0;
      chain_hi = TOP_HALF_BYPASS ? 3'd7 : 3'd3;
    end else begin
      chain_lo = ctrl_reg[lcac_pkg::CTRL_START_FIFTH] ? 3'd4 : 3'd0;
      chain_hi = 3'd7;
    end
  end

  // Subtract from the static bit or from shared input b of the first cell
  assign subtract = ctrl_reg[lcac_pkg::CTRL_SUBTRACT] |
                    (ctrl_reg[lcac_pkg::CTRL_SHARED_CTL] & CELL_DATA[lcac_pkg::IN_SHARED_B]);

  // A chain that begins here takes its carry-in from the subtract control
  assign cin_start = ctrl_reg[lcac_pkg::CTRL_CHAIN_FIRST] ? subtract : CARRY_IN;
  assign sin_start = ctrl_reg[lcac_pkg::CTRL_CHAIN_FIRST] ? 1'b0 : SHARE_IN;

  // Cell datapath, rippling both chains through the cells in order
  always_comb begin
    comb_val = 16'h0000;
    c_run    = cin_start;
    s_run    = sin_start;
    cd       = 8'h00;
    in_chain = 1'b0;
    opa0     = 1'b0;
    opb0     = 1'b0;
    opa1     = 1'b0;
    opb1     = 1'b0;
    cr0      = 1'b0;
    cr1      = 1'b0;
    ci0      = 1'b0;
    co0      = 1'b0;
    co1      = 1'b0;
    sm0      = 1'b0;
    sm1      = 1'b0;
    fa5      = 1'b0;
    fb5      = 1'b0;
    for (int i = 0; i < lcac_pkg::CELLS; i++) begin
      cd       = CELL_DATA[lcac_pkg::CELL_INS*i +: lcac_pkg::CELL_INS];
      in_chain = (i >= int'(chain_lo)) && (i <= int'(chain_hi));
      cr0      = 1'b0;
      cr1      = 1'b0;
      unique case (mode)
        lcac_pkg::MODE_EXTENDED: begin
          // Two five-input functions share a..d; upper input 0 picks one
          fa5 = lut5(mask_a_reg, {cd[lcac_pkg::IN_E0], cd[lcac_pkg::IN_D], cd[lcac_pkg::IN_C],
                                  cd[lcac_pkg::IN_SHARED_B], cd[lcac_pkg::IN_SHARED_A]});
          fb5 = lut5(mask_b_reg, {cd[lcac_pkg::IN_E1], cd[lcac_pkg::IN_D], cd[lcac_pkg::IN_C],
                                  cd[lcac_pkg::IN_SHARED_B], cd[lcac_pkg::IN_SHARED_A]});
          opa0 = cd[lcac_pkg::IN_UPPER_0] ? fb5 : fa5;
          opb0 = 1'b0;
          opa1 = 1'b0;
          opb1 = 1'b0;
        end
        lcac_pkg::MODE_SHARED: begin
          // Sum and carry tables of three operands; upper inputs stay unused
          opa0 = cd[lcac_pkg::IN_SHARED_A] ^ cd[lcac_pkg::IN_SHARED_B] ^ cd[lcac_pkg::IN_C];
          cr0  = majority(cd[lcac_pkg::IN_SHARED_A], cd[lcac_pkg::IN_SHARED_B], cd[lcac_pkg::IN_C]);
          opa1 = cd[lcac_pkg::IN_D] ^ cd[lcac_pkg::IN_E0] ^ cd[lcac_pkg::IN_E1];
          cr1  = majority(cd[lcac_pkg::IN_D], cd[lcac_pkg::IN_E0], cd[lcac_pkg::IN_E1]);
          opb0 = in_chain ? s_run : 1'b0;
          opb1 = in_chain ? cr0 : 1'b0;
        end
        default: begin
          // Pre-adder tables all see shared inputs a and b
          opa0 = lut4(mask_a_reg[15:0], {cd[lcac_pkg::IN_E0], cd[lcac_pkg::IN_C],
                                          cd[lcac_pkg::IN_SHARED_B], cd[lcac_pkg::IN_SHARED_A]});
          opb0 = lut4(mask_a_reg[31:16], {cd[lcac_pkg::IN_E0], cd[lcac_pkg::IN_C],
                                           cd[lcac_pkg::IN_SHARED_B], cd[lcac_pkg::IN_SHARED_A]}) ^ subtract;
          opa1 = lut4(mask_b_reg[15:0], {cd[lcac_pkg::IN_E1], cd[lcac_pkg::IN_D],
                                          cd[lcac_pkg::IN_SHARED_B], cd[lcac_pkg::IN_SHARED_A]});
          opb1 = lut4(mask_b_reg[31:16], {cd[lcac_pkg::IN_E1], cd[lcac_pkg::IN_D],
                                           cd[lcac_pkg::IN_SHARED_B], cd[lcac_pkg::IN_SHARED_A]}) ^ subtract;
        end
      endcase
      // Two full adders in series; cells outside the chain see no carry
      ci0 = in_chain ? c_run : 1'b0;
      sm0 = opa0 ^ opb0 ^ ci0;
      co0 = majority(opa0, opb0, ci0);
      sm1 = opa1 ^ opb1 ^ co0;
      co1 = majority(opa1, opb1, co0);
      if (in_chain) begin
        c_run = co1;
        if (mode == lcac_pkg::MODE_SHARED) begin
          s_run = cr1;
        end
      end
      if (mode == lcac_pkg::MODE_EXTENDED) begin
        comb_val[2*i] = opa0;
      end else if (ctrl_reg[lcac_pkg::CTRL_CARRY_ONLY]) begin
        comb_val[2*i +: 2] = {opa1, opa0};
      end else begin
        comb_val[2*i +: 2] = {sm1, sm0};
      end
    end
  end

  // Final carry may steer the cluster load, giving max-select of X and Y
  assign load_sel = SYNC_LOAD | (ctrl_reg[lcac_pkg::CTRL_CARRY_LOAD] & c_run);

  // Per-cell counter enable from shared input a, when enabled
  always_comb begin
    for (int i = 0; i < lcac_pkg::CELLS; i++) begin
      cnt_en[i] = ~ctrl_reg[lcac_pkg::CTRL_SHARED_CTL] |
                  CELL_DATA[lcac_pkg::CELL_INS*i + lcac_pkg::IN_SHARED_A];
    end
  end

  // Data source of each register: chain, packed upper input, or cell result
  always_comb begin
    for (int k = 0; k < lcac_pkg::CELL_REGS; k++) begin
      reg_we[k] = CLK_ENABLE & cnt_en[k/2];
      if (ctrl_reg[lcac_pkg::CTRL_REG_CHAIN]) begin
        reg_next[k] = (k == 0) ? REG_CHAIN_IN : regs_reg[(k == 0) ? 0 : k-1];
      end else if (ctrl_reg[lcac_pkg::CTRL_PACK_UPPER] && mode != lcac_pkg::MODE_EXTENDED) begin
        reg_next[k] = CELL_DATA[lcac_pkg::CELL_INS*(k/2) +
                                ((k % 2 == 0) ? lcac_pkg::IN_UPPER_0 : lcac_pkg::IN_UPPER_1)];
      end else begin
        reg_next[k] = comb_val[k];
      end
      if (mode == lcac_pkg::MODE_EXTENDED && !ctrl_reg[lcac_pkg::CTRL_REG_CHAIN]) begin
        if (k % 2 == 1) begin
          reg_we[k] = 1'b0;
        end else if (ctrl_reg[lcac_pkg::CTRL_EXT_UNREG]) begin
          reg_next[k] = CELL_DATA[lcac_pkg::CELL_INS*(k/2) + lcac_pkg::IN_UPPER_1];
        end
      end
    end
  end

  // Cell registers; async clear beats async preset, both force constants
  always_ff @(posedge CLK_SYS or posedge CELL_ACLR or posedge CELL_APRESET) begin
    if (CELL_ACLR) begin
      regs_reg <= 16'h0000;
    end else if (CELL_APRESET) begin
      regs_reg <= 16'hFFFF;
    end else if (RESET) begin
      regs_reg <= lcac_pkg::REGS_RESET;
    end else if (SYNC_CLEAR) begin
      regs_reg <= 16'h0000;
    end else if (load_sel) begin
      regs_reg <= ALT_DATA;
    end else begin
      for (int k = 0; k < lcac_pkg::CELL_REGS; k++) begin
        if (reg_we[k]) begin
          regs_reg[k] <= reg_next[k];
        end
      end
    end
  end

  assign REG_OUT       = regs_reg;
  assign REG_CHAIN_OUT = regs_reg[lcac_pkg::CELL_REGS-1];

  // Unregistered results and chain ends are retimed so every pin leaves a flop
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      COMB_OUT      <= 16'h0000;
      CARRY_OUT     <= 1'b0;
      ROUTED_CARRY  <= 1'b0;
      SHARE_OUT     <= 1'b0;
      load_seen_reg <= 1'b0;
    end else begin
      COMB_OUT      <= comb_val;
      CARRY_OUT     <= c_run;
      ROUTED_CARRY  <= c_run;
      SHARE_OUT     <= s_run;
      load_seen_reg <= load_sel;
    end
  end

endmodule : lcac_cluster

// ---- shared/lcac_pkg.sv ----
package lcac_pkg;

  // Cluster geometry
  localparam int CELLS      = 8;
  localparam int CELL_REGS  = 2 * CELLS;
  localparam int CELL_INS   = 8;
  localparam int HALF_CELLS = 4;

  // Position of each data input inside one cell's input byte
  localparam int IN_SHARED_A = 0;
  localparam int IN_SHARED_B = 1;
  localparam int IN_C        = 2;
  localparam int IN_D        = 3;
  localparam int IN_E0       = 4;
  localparam int IN_UPPER_0  = 5;
  localparam int IN_E1       = 6;
  localparam int IN_UPPER_1  = 7;

  // APB byte addresses
  localparam logic [7:0] OFFS_CTRL   = 8'h00;
  localparam logic [7:0] OFFS_MASK_A = 8'h04;
  localparam logic [7:0] OFFS_MASK_B = 8'h08;
  localparam logic [7:0] OFFS_STATUS = 8'h0C;

  // Control register fields
  localparam int CTRL_MODE_LO      = 0;
  localparam int CTRL_START_FIFTH  = 2;
  localparam int CTRL_HALF_CHAIN   = 3;
  localparam int CTRL_REG_CHAIN    = 4;
  localparam int CTRL_EXT_UNREG    = 5;
  localparam int CTRL_CARRY_ONLY   = 6;
  localparam int CTRL_PACK_UPPER   = 7;
  localparam int CTRL_CARRY_LOAD   = 8;
  localparam int CTRL_SHARED_CTL   = 9;
  localparam int CTRL_SUBTRACT     = 10;
  localparam int CTRL_CHAIN_FIRST  = 11;
  localparam int CTRL_WIDTH        = 12;

  // Status register fields
  localparam int STAT_CARRY        = 16;
  localparam int STAT_SHARE        = 17;
  localparam int STAT_LOAD_SEL     = 18;

  // Values after reset
  localparam logic [CTRL_WIDTH-1:0] CTRL_RESET   = 12'h0801;
  localparam logic [31:0]           MASK_RESET   = 32'h0000_0000;
  localparam logic [CELL_REGS-1:0]  REGS_RESET   = 16'h0000;

  // Cell operating modes; the fourth code is illegal and falls back to arithmetic
  typedef enum logic [1:0] {
    MODE_EXTENDED,
    MODE_ARITH,
    MODE_SHARED
  } lcac_mode_e;

endpackage : lcac_pkg

// ---- verification/lcac_cluster_sva.sv ----
`timescale 1ns/1ps

// Port-level checks of the cell cluster
module lcac_cluster_chk (
  input wire logic        CLK_SYS,
  input wire logic        RESET,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        SYNC_CLEAR,
  input wire logic        SYNC_LOAD,
  input wire logic [15:0] ALT_DATA,
  input wire logic        CELL_ACLR,
  input wire logic        CELL_APRESET,
  input wire logic [15:0] REG_OUT,
  input wire logic        CARRY_OUT,
  input wire logic        ROUTED_CARRY,
  input wire logic        REG_CHAIN_OUT
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);

  // Bus timing: one access cycle, never a wait
  a_ready_after_setup: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("pready missing after setup");
  a_ready_one_cycle: assert property (PREADY |=> !PREADY)
    else $error("pready held too long");
  a_err_unmapped: assert property (PSEL && !PENABLE && PADDR > 8'h0C |=> PSLVERR && PRDATA == 32'h0000_0000)
    else $error("unmapped access not refused");

  // Cluster-wide controls; async ones are excluded since they override
  a_load_alt: assert property (SYNC_LOAD && !SYNC_CLEAR && !CELL_ACLR && !CELL_APRESET ##1 !CELL_ACLR && !CELL_APRESET
    |-> REG_OUT == $past(ALT_DATA)) else $error("sync load missed");
  a_clear_wins: assert property (SYNC_CLEAR && !CELL_APRESET ##1 !CELL_APRESET |-> REG_OUT == 16'h0000)
    else $error("sync clear missed");
  a_async_clear: assert property (CELL_ACLR |-> REG_OUT == 16'h0000)
    else $error("async clear missed");
  a_preset_ones: assert property (CELL_APRESET && !CELL_ACLR |-> REG_OUT == 16'hFFFF)
    else $error("async preset missed");
  a_chain_tail: assert property (REG_CHAIN_OUT == REG_OUT[15])
    else $error("chain output not last register");
  a_routed_carry: assert property (CARRY_OUT == ROUTED_CARRY)
    else $error("routed carry differs");

  c_load: cover property (SYNC_LOAD);
  c_carry: cover property ($rose(CARRY_OUT));
  c_refused: cover property (PSLVERR);
endmodule : lcac_cluster_chk

bind lcac_cluster lcac_cluster_chk u_chk (
  .CLK_SYS(CLK_SYS), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .SYNC_CLEAR(SYNC_CLEAR), .SYNC_LOAD(SYNC_LOAD), .ALT_DATA(ALT_DATA),
  .CELL_ACLR(CELL_ACLR), .CELL_APRESET(CELL_APRESET), .REG_OUT(REG_OUT), .CARRY_OUT(CARRY_OUT),
  .ROUTED_CARRY(ROUTED_CARRY), .REG_CHAIN_OUT(REG_CHAIN_OUT)
);

// ---- verification/lcac_cluster_test.sv ----
`timescale 1ns/1ps

module lcac_cluster_test;
  typedef struct {logic [11:0] ctrl; logic [31:0] ma; logic [63:0] d; logic cin; logic [15:0] sum; logic c;} lcac_row_s;
  logic        clk, rst, psel, penable, pwrite, cin_set, ld, clk_en, sclr, sload, aclr, apre, er;
  logic        pready, pslverr, carry_out, routed, share_out, chain_out, cin, shin, chin;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [63:0] cdata;
  logic [15:0] alt, pat, comb_out, reg_out;
  int          errors, n_checks;
  lcac_row_s   rows[11];

  lcac_cluster u_dut (.CLK_SYS(clk), .RESET(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .CELL_DATA(cdata),
    .CARRY_IN(cin), .SHARE_IN(shin), .REG_CHAIN_IN(chin), .CLK_ENABLE(clk_en), .SYNC_CLEAR(sclr),
    .SYNC_LOAD(sload), .ALT_DATA(alt), .CELL_ACLR(aclr), .CELL_APRESET(apre), .COMB_OUT(comb_out),
    .REG_OUT(reg_out), .CARRY_OUT(carry_out), .ROUTED_CARRY(routed), .SHARE_OUT(share_out),
    .REG_CHAIN_OUT(chain_out));
  lcac_prev_cluster u_prev (.clk(clk), .rst(rst), .load(ld), .pattern(pat), .carry_set(cin_set),
    .share_set(1'b0), .carry_out(cin), .share_out(shin), .chain_out(chin));

  // Clock
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end

  // Operand x on tables c/d, operand y on e0/e1, two bits per cell
  function automatic logic [63:0] mk(input logic [15:0] x, input logic [15:0] y);
    logic [63:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      r[8*i+2] = x[2*i];
      r[8*i+3] = x[2*i+1];
      r[8*i+4] = y[2*i];
      r[8*i+6] = y[2*i+1];
    end
    return r;
  endfunction : mk

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task chkb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask : chkb

  task tally_and_finish;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  // One transfer; holds the request until pready is seen at an edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    for (i = 0; i < 16; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      errors++;
      $display("wrong value at %0t: no ready", $time);
      tally_and_finish();
    end
    rd = prdata; er = pslverr;
    psel <= 0; penable <= 0;
  endtask : apb

  task run_row(input lcac_row_s r);
    apb(1, lcac_pkg::OFFS_CTRL, 32'(r.ctrl));
    apb(1, lcac_pkg::OFFS_MASK_A, r.ma);
    apb(1, lcac_pkg::OFFS_MASK_B, r.ma);
    cdata <= r.d; cin_set <= r.cin;
    repeat (3) @(posedge clk);
    #1;
    chk(comb_out, r.sum);
    chkb(carry_out, r.c);
    chkb(routed, r.c);
    if (r.ctrl[1:0] == 2'd2) chkb(share_out, 1'b1);
    if (!r.ctrl[6]) chk(reg_out, r.sum);
    else if (r.ctrl[8]) chk(reg_out, r.c ? {16'h0000, alt} : {16'h0000, r.sum});
  endtask : run_row

  // Main sequence
  initial begin
    {rst, clk_en} = 2'b11;
    {psel, penable, pwrite, cin_set, ld, sclr, sload, aclr, apre, errors, n_checks} = '0;
    {paddr, pwdata, cdata, pat} = '0;
    alt = 16'h0020;
    rows[0] = '{12'h801, 32'hFF00_F0F0, mk(16'h1234, 16'h4321), 1'b0, 16'h5555, 1'b0};
    rows[1] = '{12'h801, 32'hFF00_F0F0, mk(16'hFFFF, 16'h0001), 1'b0, 16'h0000, 1'b1};
    rows[2] = '{12'hC01, 32'hFF00_F0F0, mk(16'h0005, 16'h0003), 1'b0, 16'h0002, 1'b1};
    rows[3] = '{12'hC01, 32'hFF00_F0F0, mk(16'h0003, 16'h0005), 1'b0, 16'hFFFE, 1'b0};
    rows[4] = '{12'h001, 32'hFF00_F0F0, mk(16'h00FF, 16'h0000), 1'b1, 16'h0100, 1'b0};
    rows[5] = '{12'h809, 32'hFF00_F0F0, mk(16'h0F00, 16'h0100), 1'b0, 16'h1000, 1'b0};
    rows[6] = '{12'h805, 32'hFF00_F0F0, mk(16'hFF00, 16'h0100), 1'b0, 16'h0000, 1'b1};
    rows[7] = '{12'h841, 32'hFF00_F0F0, mk(16'h8000, 16'h8000), 1'b0, 16'h8000, 1'b1};
    rows[8] = '{12'h802, 32'hFF00_F0F0, 64'h1800_0000_0000_0007, 1'b0, 16'h0003, 1'b0};
    rows[9] = '{12'h941, 32'hFF00_0F0F, mk(16'h0010, 16'h0020), 1'b0, 16'hFFEF, 1'b1};
    rows[10] = '{12'h941, 32'hFF00_0F0F, mk(16'h0030, 16'h0020), 1'b0, 16'hFFCF, 1'b0};
    repeat (8) @(posedge clk);
    rst <= 0;
    #1 chk(reg_out, 32'h0000_0000);
    chkb(pready, 1'b0);
    apb(0, lcac_pkg::OFFS_CTRL, 32'h0);
    chk(rd, 32'(lcac_pkg::CTRL_RESET));
    apb(0, lcac_pkg::OFFS_MASK_A, 32'h0);
    chk(rd, lcac_pkg::MASK_RESET);
    apb(0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    chkb(er, 1'b1);
    apb(1, lcac_pkg::OFFS_STATUS, 32'hFFFF_FFFF);
    apb(0, lcac_pkg::OFFS_STATUS, 32'h0);
    chk(rd, 32'h0);
    foreach (rows[i]) run_row(rows[i]);
    // Shift register fed from the neighbour while tables add; plain add tables again
    apb(1, lcac_pkg::OFFS_MASK_A, 32'hFF00_F0F0);
    apb(1, lcac_pkg::OFFS_MASK_B, 32'hFF00_F0F0);
    apb(1, lcac_pkg::OFFS_CTRL, 32'h0000_0811);
    cdata <= mk(16'h0001, 16'h0001); pat <= 16'hB38E; ld <= 1;
    @(posedge clk);
    ld <= 0;
    repeat (16) @(posedge clk);
    #1 chk(reg_out, 16'hB38E);
    chk(comb_out, 16'h0002);
    chkb(chain_out, 1'b1);
    // Load and clear ignore the clock enable; clear beats load
    apb(1, lcac_pkg::OFFS_CTRL, 32'(lcac_pkg::CTRL_RESET));
    clk_en <= 0; sload <= 1; alt <= 16'hA5C3;
    @(posedge clk);
    sload <= 0; cdata <= mk(16'h1111, 16'h1111);
    repeat (2) @(posedge clk);
    #1 chk(reg_out, 16'hA5C3);
    @(posedge clk);
    sclr <= 1; sload <= 1;
    @(posedge clk);
    sclr <= 0; sload <= 0; clk_en <= 1;
    #1 chk(reg_out, 16'h0000);
    @(posedge clk);
    #1 chk(reg_out, 16'h2222);
    // Async preset, then clear on top of it
    @(posedge clk);
    apre <= 1;
    @(posedge clk);
    #1 chk(reg_out, 16'hFFFF);
    @(posedge clk);
    aclr <= 1;
    @(posedge clk);
    #1 chk(reg_out, 16'h0000);
    @(posedge clk);
    aclr <= 0; apre <= 0;
    // Second reset mid-run
    apb(1, lcac_pkg::OFFS_CTRL, 32'h0000_0C01);
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    #1 chk(reg_out, 16'h0000);
    apb(0, lcac_pkg::OFFS_CTRL, 32'h0);
    chk(rd, 32'(lcac_pkg::CTRL_RESET));
    tally_and_finish();
  end
endmodule : lcac_cluster_test

// ---- verification/lcac_prev_cluster.sv ----
`timescale 1ns/1ps

module lcac_prev_cluster (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        load,
  input  wire logic [15:0] pattern,
  input  wire logic        carry_set,
  input  wire logic        share_set,
  output logic             carry_out,
  output logic             share_out,
  output logic             chain_out
);
  logic [15:0] shift_reg;

  // Register chain source, oldest bit leaves first
  always_ff @(posedge clk) begin
    if (rst) shift_reg <= 16'h0000;
    else if (load) shift_reg <= pattern;
    else shift_reg <= {shift_reg[14:0], 1'b0};
  end
  assign chain_out = shift_reg[15];

  // Chain carries leave a flop, so they arrive a cycle late
  always_ff @(posedge clk) begin
    carry_out <= rst ? 1'b0 : carry_set;
    share_out <= rst ? 1'b0 : share_set;
  end
endmodule : lcac_prev_cluster
